// >>> src/rsc_pkg.sv
package rsc_pkg;

    // Core clock period and the least time that the internal reset is held.
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RESET_HOLD_NS = 1000;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register offsets, byte addresses on the register bus.
    localparam logic [11:0] OFS_CAUSE = 12'h000;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h008;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h00C;
    localparam logic [11:0] OFS_REGION_BASE = 12'h010;
    localparam logic [11:0] OFS_REGION_LIMIT = 12'h014;
    localparam logic [11:0] OFS_CONTROL = 12'h018;
    localparam logic [11:0] OFS_START = 12'h01C;

    // Cause flag positions, shared by the cause and interrupt registers.
    localparam int unsigned BIT_LVD = 0;
    localparam int unsigned BIT_PARITY = 1;
    localparam int unsigned BIT_ACCESS = 2;
    localparam int unsigned BIT_WDT = 4;
    localparam int unsigned BIT_TRAP = 7;

    // Control fields and reset values.
    localparam int unsigned CTRL_GUARD_EN = 0;
    localparam int unsigned CTRL_PARITY_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [19:0] REGION_RESET = 20'h00000;
    localparam int unsigned START_RUN_BIT = 16;

    // Opcode that traps, and the two bytes of the reset vector.
    localparam logic [7:0] ILLEGAL_OPCODE = 8'hFF;
    localparam logic [19:0] VEC_LO_ADDR = 20'h00000;
    localparam logic [19:0] VEC_HI_ADDR = 20'h00001;

    // Synchroniser idle levels: pin high, detectors low.
    localparam logic [2:0] SYNC_IDLE = 3'h1;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_VEC_END,
        ST_RUN
    } rsc_state_type;

endpackage

// >>> src/rsc_top.sv
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
// Operation
// - A low level on the external reset pin holds the device in reset.
// - A watchdog runaway-loop report raises an internal reset.
// - Power-on or supply-voltage detector crossing raises an internal reset.
// - Fetching opcode FFH is illegal and raises an internal reset.
// - Reading a never-written RAM word is a parity error and raises reset.
// - Any access inside the guarded memory region raises an internal reset.
// - After release the start address comes from bytes 00000H and 00001H.
// - Execution resumes on the on-chip oscillator at the option-byte frequency.
// - A cause flag records a watchdog reset.
// - A cause flag records a low-voltage detector reset.
// - A cause flag records an illegal-instruction reset.
// - A cause flag records a RAM parity reset.
// - A cause flag records an illegal-access reset.
module rsc_top #(
    parameter int unsigned RAM_WORDS = 64,
    parameter int unsigned RAM_AW = 6,
    parameter int unsigned HOLD_CYCLES = rsc_pkg::RESET_HOLD_CYC,
    parameter int unsigned FREQ_W = 3
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RESET_PIN_N,
    input wire logic POR_DET,
    input wire logic LVD_DET,
    input wire logic WDT_LOOP,
    input wire logic OPCODE_FETCH,
    input wire logic [7:0] OPCODE,
    input wire logic RAM_WR,
    input wire logic RAM_RD,
    input wire logic [RAM_AW-1:0] RAM_ADDR,
    input wire logic MEM_ACCESS,
    input wire logic [19:0] MEM_ADDR,
    input wire logic [FREQ_W-1:0] OPT_FREQ,
    output logic VEC_RD,
    output logic [19:0] VEC_ADDR,
    input wire logic [7:0] VEC_DATA,
    output logic CORE_RESET_N,
    output logic START_VALID,
    output logic [15:0] START_ADDR,
    output logic HS_OSC_RUN,
    output logic [FREQ_W-1:0] OSC_FREQ_SEL,
    output logic IRQ
);
    import rsc_pkg::*;

    localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

    // The parity map is indexed directly by the address, so it must be a full power of two.
    if (RAM_WORDS != (1 << RAM_AW)) begin : g_bad_ram
        $error("RAM_WORDS must equal two to the power RAM_AW.");
    end
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one.");
    end
    if (FREQ_W < 1 || FREQ_W > 8) begin : g_bad_freq
        $error("FREQ_W must lie between one and eight.");
    end

    // Decode used by the error answer; the read answer decodes in its own case.
    function automatic logic reg_known(input logic [11:0] addr);
        reg_known = (addr == OFS_CAUSE) || (addr == OFS_IRQ_STATUS) ||
                    (addr == OFS_IRQ_CLEAR) || (addr == OFS_IRQ_ENABLE) ||
                    (addr == OFS_REGION_BASE) || (addr == OFS_REGION_LIMIT) ||
                    (addr == OFS_CONTROL) || (addr == OFS_START);
    endfunction

    logic [2:0] async_in;
    logic [2:0] meta_q;
    logic [2:0] mid_q;
    logic [2:0] late_q;
    logic [2:0] level_q;
    logic pin_low;
    logic por_on;
    logic lvd_on;
    logic trap_ev;
    logic parity_ev;
    logic access_ev;
    logic reset_req;
    logic clr_all;
    logic [7:0] set_vec;
    logic [7:0] cause_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_enable_q;
    logic [1:0] ctrl_q;
    logic [19:0] region_base_q;
    logic [19:0] region_limit_q;
    logic [RAM_WORDS-1:0] written_q;
    logic [CNT_W-1:0] hold_cnt_q;
    rsc_state_type state_q;
    logic [7:0] vec_lo_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] read_mux;
    logic setup;
    logic wr_done;
    logic rd_done;
    logic irq_q;

    // Pin and analog detector inputs arrive from outside the clock domain.
    assign async_in = {LVD_DET, POR_DET, RESET_PIN_N};

    // Four flops each; the level moves only once the second and third agree.
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                meta_q[i] <= SYNC_IDLE[i];
                mid_q[i] <= SYNC_IDLE[i];
                late_q[i] <= SYNC_IDLE[i];
                level_q[i] <= SYNC_IDLE[i];
            end else begin
                meta_q[i] <= async_in[i];
                mid_q[i] <= meta_q[i];
                late_q[i] <= mid_q[i];
                if (mid_q[i] == late_q[i]) begin
                    level_q[i] <= late_q[i];
                end
            end
        end
    end

    assign pin_low = ~level_q[0];
    assign por_on = level_q[1];
    assign lvd_on = level_q[2];

    // Events from core logic on this clock need no synchroniser.
    assign trap_ev = OPCODE_FETCH && (OPCODE == ILLEGAL_OPCODE);
    assign parity_ev = ctrl_q[CTRL_PARITY_EN] && RAM_RD && !written_q[RAM_ADDR];
    assign access_ev = ctrl_q[CTRL_GUARD_EN] && MEM_ACCESS &&
                       (MEM_ADDR >= region_base_q) && (MEM_ADDR <= region_limit_q);

    // Every source folds into one request; the pin is level-held by the supervisor.
    assign reset_req = pin_low ||
                       WDT_LOOP ||
                       por_on || lvd_on ||
                       trap_ev || parity_ev || access_ev;

    // The pin and power-on start a fresh history, so they wipe the cause flags.
    assign clr_all = pin_low || por_on;

    // Map each internal source except power-on onto its cause bit.
    always_comb begin
        set_vec = 8'h00;
        set_vec[BIT_WDT] = WDT_LOOP;
        set_vec[BIT_LVD] = lvd_on;
        set_vec[BIT_TRAP] = trap_ev;
        set_vec[BIT_PARITY] = parity_ev;
        set_vec[BIT_ACCESS] = access_ev;
    end

    // Record each word that was ever written; power loss forgets all of them.
    for (genvar w = 0; w < RAM_WORDS; w++) begin : g_written
        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                written_q[w] <= 1'b0;
            end else if (RAM_WR && (RAM_ADDR == RAM_AW'(w))) begin
                written_q[w] <= 1'b1;
            end else if (por_on) begin
                written_q[w] <= 1'b0;
            end
        end
    end

    // Bus phases; the answer is registered during setup so access needs no wait.
    assign setup = PSEL && !PENABLE;
    assign wr_done = PSEL && PENABLE && pready_q && PWRITE;
    assign rd_done = PSEL && PENABLE && pready_q && !PWRITE;

    // Read data selection; write-only and unmapped words read as zero.
    always_comb begin
        read_mux = 32'h00000000;
        unique case (PADDR)
            OFS_CAUSE: read_mux[7:0] = cause_q;
            OFS_IRQ_STATUS: read_mux[7:0] = irq_status_q;
            OFS_IRQ_ENABLE: read_mux[7:0] = irq_enable_q;
            OFS_REGION_BASE: read_mux[19:0] = region_base_q;
            OFS_REGION_LIMIT: read_mux[19:0] = region_limit_q;
            OFS_CONTROL: read_mux[1:0] = ctrl_q;
            OFS_START: read_mux[START_RUN_BIT:0] = {state_q == ST_RUN, START_ADDR};
            default: read_mux = 32'h00000000;
        endcase
    end

    // Bus answer flops: one ready cycle per transfer, error for unmapped words.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !reg_known(PADDR);
            if (setup && !PWRITE) begin
                prdata_q <= read_mux;
            end else if (setup) begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    // Cause flags live outside the internal reset so they outlast it.
    // A read clears only the bits it returned, so a flag raised between setup
    // and access is not lost; a new set always beats the clear.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cause_q <= 8'h00;
        end else begin
            cause_q <= (cause_q & ~(clr_all ? 8'hFF : 8'h00) &
                        ~((rd_done && PADDR == OFS_CAUSE) ? prdata_q[7:0] : 8'h00)) | set_vec;
        end
    end

    // Software-owned settings: guard region, check enables, interrupt mask.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= CTRL_RESET;
            irq_enable_q <= IRQ_ENABLE_RESET;
            region_base_q <= REGION_RESET;
            region_limit_q <= REGION_RESET;
        end else if (wr_done) begin
            if (PADDR == OFS_CONTROL) begin
                ctrl_q <= PWDATA[1:0];
            end
            if (PADDR == OFS_IRQ_ENABLE) begin
                irq_enable_q <= PWDATA[7:0];
            end
            if (PADDR == OFS_REGION_BASE) begin
                region_base_q <= PWDATA[19:0];
            end
            if (PADDR == OFS_REGION_LIMIT) begin
                region_limit_q <= PWDATA[19:0];
            end
        end
    end

    // Sticky interrupt status; writing ones clears, and a same-cycle event wins.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_status_q <= 8'h00;
        end else begin
            irq_status_q <= (irq_status_q &
                             ~((wr_done && PADDR == OFS_IRQ_CLEAR) ? PWDATA[7:0] : 8'h00)) | set_vec;
        end
    end

    // Level interrupt, registered so the pin never glitches.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_enable_q);
        end
    end

    // Reset sequence: hold, fetch the two vector bytes, then let the core run.
    // Any request, even mid-fetch, restarts the hold from zero.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_HOLD;
            hold_cnt_q <= '0;
        end else if (reset_req) begin
            state_q <= ST_HOLD;
            hold_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    if (hold_cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
                        state_q <= ST_VEC_LO;
                        hold_cnt_q <= '0;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 1'b1;
                    end
                end
                ST_VEC_LO: state_q <= ST_VEC_HI;
                ST_VEC_HI: state_q <= ST_VEC_END;
                ST_VEC_END: state_q <= ST_RUN;
                ST_RUN: state_q <= ST_RUN;
            endcase
        end
    end

    // Vector read port; the memory answers one cycle after it sees the address.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            VEC_RD <= 1'b0;
            VEC_ADDR <= VEC_LO_ADDR;
        end else if (reset_req) begin
            VEC_RD <= 1'b0;
            VEC_ADDR <= VEC_LO_ADDR;
        end else if (state_q == ST_HOLD && hold_cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
            VEC_RD <= 1'b1;
            VEC_ADDR <= VEC_LO_ADDR;
        end else if (state_q == ST_VEC_LO) begin
            VEC_ADDR <= VEC_HI_ADDR;
        end else if (state_q == ST_VEC_HI) begin
            VEC_RD <= 1'b0;
        end
    end

    // Assemble the start address, low byte first, and release the core.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            vec_lo_q <= 8'h00;
            START_ADDR <= 16'h0000;
            START_VALID <= 1'b0;
            CORE_RESET_N <= 1'b0;
        end else begin
            START_VALID <= 1'b0;
            if (reset_req) begin
                CORE_RESET_N <= 1'b0;
            end else if (state_q == ST_VEC_HI) begin
                vec_lo_q <= VEC_DATA;
            end else if (state_q == ST_VEC_END) begin
                START_ADDR <= {VEC_DATA, vec_lo_q};
                START_VALID <= 1'b1;
                CORE_RESET_N <= 1'b1;
            end
        end
    end

    // Clock for the core: the on-chip oscillator at the option-byte frequency.
    // The option byte is sampled once per release, so a change in run takes
    // effect only after the next reset.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            HS_OSC_RUN <= 1'b0;
            OSC_FREQ_SEL <= '0;
        end else if (reset_req) begin
            HS_OSC_RUN <= 1'b0;
        end else if (state_q == ST_HOLD && hold_cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
            OSC_FREQ_SEL <= OPT_FREQ;
        end else if (state_q == ST_VEC_END) begin
            HS_OSC_RUN <= 1'b1;
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;
    assign IRQ = irq_q;

endmodule

// >>> verif/rsc_monitor.sv
`timescale 1ns/1ns
// Pin-level checks of the reset sequencer; it sees only the ports.
module rsc_monitor
    import rsc_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 4,
    parameter int unsigned FREQ_W = 3
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic RESET_PIN_N,
    input wire logic POR_DET,
    input wire logic WDT_LOOP,
    input wire logic OPCODE_FETCH,
    input wire logic [7:0] OPCODE,
    input wire logic [FREQ_W-1:0] OPT_FREQ,
    input wire logic VEC_RD,
    input wire logic [19:0] VEC_ADDR,
    input wire logic [7:0] VEC_DATA,
    input wire logic CORE_RESET_N,
    input wire logic START_VALID,
    input wire logic [15:0] START_ADDR,
    input wire logic HS_OSC_RUN,
    input wire logic [FREQ_W-1:0] OSC_FREQ_SEL
);
    // One clock domain, so one default clock and disable for all checks.
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Synchronised sources may need up to five edges to reach the core.
    a_pin_hold: assert property (!RESET_PIN_N [*5] |=> !CORE_RESET_N)
        else $error("pin low did not reset core");
    a_por_hold: assert property (POR_DET [*5] |=> !CORE_RESET_N)
        else $error("power-on detect did not reset core");
    a_wdt_reset: assert property (WDT_LOOP |=> !CORE_RESET_N && !HS_OSC_RUN)
        else $error("watchdog report did not reset core");
    a_trap_reset: assert property (OPCODE_FETCH && OPCODE == ILLEGAL_OPCODE |=> !CORE_RESET_N)
        else $error("illegal opcode did not reset core");
    // The fetch must wait at least the hold time used by the bench.
    a_hold_first: assert property ($fell(CORE_RESET_N) |-> !VEC_RD [*4])
        else $error("vector fetch began inside hold time");
    a_vec_order: assert property ($rose(VEC_RD) |-> VEC_ADDR == VEC_LO_ADDR
        ##1 VEC_RD && VEC_ADDR == VEC_HI_ADDR ##1 !VEC_RD)
        else $error("vector bytes fetched out of order");
    a_start_word: assert property (START_VALID |->
        START_ADDR == {$past(VEC_DATA), $past(VEC_DATA, 2)} && CORE_RESET_N)
        else $error("start address not built from vector bytes");
    a_osc_resume: assert property (START_VALID |->
        HS_OSC_RUN && OSC_FREQ_SEL == OPT_FREQ ##1 !START_VALID)
        else $error("core resumed without selected oscillator");
    a_ready_once: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("register bus answer not one cycle");

    cover property (START_VALID);
    cover property (WDT_LOOP);
    cover property (!RESET_PIN_N [*5]);
endmodule

bind rsc_top rsc_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .FREQ_W(FREQ_W)) u_mon (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .RESET_PIN_N(RESET_PIN_N), .POR_DET(POR_DET), .WDT_LOOP(WDT_LOOP),
    .OPCODE_FETCH(OPCODE_FETCH), .OPCODE(OPCODE), .OPT_FREQ(OPT_FREQ),
    .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR), .VEC_DATA(VEC_DATA), .CORE_RESET_N(CORE_RESET_N),
    .START_VALID(START_VALID), .START_ADDR(START_ADDR), .HS_OSC_RUN(HS_OSC_RUN),
    .OSC_FREQ_SEL(OSC_FREQ_SEL));

// >>> verif/rsc_supervisor.sv
`timescale 1ns/1ns
// External supervisor: holds the reset pin low for a requested count.
module rsc_supervisor (
    input wire logic clk,
    input wire logic [7:0] hold_len,
    input wire logic start,
    output logic reset_pin_n
);
    logic [7:0] cnt_q = 8'h00;

    // The pin is always driven, so it never floats between requests.
    always_ff @(posedge clk) begin
        if (start) begin
            cnt_q <= hold_len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign reset_pin_n = (cnt_q == 8'h00);
endmodule

// >>> verif/reset_source_collector_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module reset_source_collector_tb;
    import rsc_pkg::*;
    logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
    logic PREADY, PSLVERR, rerr, RESET_PIN_N, POR_DET = 0, LVD_DET = 0, WDT_LOOP = 0;
    logic OPCODE_FETCH = 0, RAM_WR = 0, RAM_RD = 0, MEM_ACCESS = 0, sup_go = 0;
    logic [7:0] OPCODE = 8'h00, VEC_DATA = 8'h00;
    logic [5:0] RAM_ADDR = 6'h00;
    logic [19:0] MEM_ADDR = 20'h00000, VEC_ADDR;
    logic [2:0] OPT_FREQ = 3'h5, OSC_FREQ_SEL;
    logic VEC_RD, CORE_RESET_N, START_VALID, HS_OSC_RUN, IRQ;
    logic [15:0] START_ADDR;
    int bad_count = 0;
    int tests_run = 0;
    int bits[5] = '{BIT_WDT, BIT_TRAP, BIT_PARITY, BIT_ACCESS, BIT_LVD};

    always #4 CLK = ~CLK;

    rsc_supervisor sup (.clk(CLK), .hold_len(8'h08), .start(sup_go), .reset_pin_n(RESET_PIN_N));

    rsc_top #(.HOLD_CYCLES(4)) dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RESET_PIN_N(RESET_PIN_N), .POR_DET(POR_DET), .LVD_DET(LVD_DET),
        .WDT_LOOP(WDT_LOOP), .OPCODE_FETCH(OPCODE_FETCH), .OPCODE(OPCODE), .RAM_WR(RAM_WR),
        .RAM_RD(RAM_RD), .RAM_ADDR(RAM_ADDR), .MEM_ACCESS(MEM_ACCESS), .MEM_ADDR(MEM_ADDR),
        .OPT_FREQ(OPT_FREQ), .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR), .VEC_DATA(VEC_DATA),
        .CORE_RESET_N(CORE_RESET_N), .START_VALID(START_VALID), .START_ADDR(START_ADDR),
        .HS_OSC_RUN(HS_OSC_RUN), .OSC_FREQ_SEL(OSC_FREQ_SEL), .IRQ(IRQ));

    // Vector memory answers a cycle late; unselected it toggles so stale data shows.
    always @(posedge CLK) begin
        VEC_DATA <= VEC_RD ? (VEC_ADDR == VEC_HI_ADDR ? 8'h12 : 8'h34) : ~VEC_DATA;
    end

    // One bus transfer; ready, read data and error are all taken at the rising edge
    // that completes the access, so the request stands until the slave answers.
    // A slave that never answers is cut off by the watchdog, not here.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        @(posedge CLK);
        while (PREADY !== 1'b1) begin
            @(posedge CLK);
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 0; PENABLE <= 0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask

    // Waits for the core to restart and checks how it came back.
    task wait_run;
        int n;
        n = 0;
        @(negedge CLK);
        while (START_VALID !== 1'b1 && n < 300) begin
            @(negedge CLK);
            n++;
        end
        `CHK(START_VALID, 1'b1)
        `CHK(START_ADDR, 16'h1234)
        `CHK({HS_OSC_RUN, OSC_FREQ_SEL}, {1'b1, OPT_FREQ})
    endtask

    // Source i fires; for sources 1 to 3, near selects a harmless neighbour that must not reset.
    task fire(input int i, input bit near);
        @(posedge CLK);
        case (i)
            0: WDT_LOOP <= 1;
            1: begin OPCODE_FETCH <= 1; OPCODE <= near ? 8'hFE : ILLEGAL_OPCODE; end
            2: begin RAM_RD <= 1; RAM_ADDR <= near ? 6'h03 : 6'h05; end
            3: begin MEM_ACCESS <= 1; MEM_ADDR <= near ? 20'h00200 : 20'h00150; end
            4: LVD_DET <= 1;
            5: POR_DET <= 1;
            default: begin RAM_WR <= 1; RAM_ADDR <= 6'h03; end
        endcase
        repeat (i >= 4 && i <= 5 ? 6 : 1) @(posedge CLK);
        {WDT_LOOP, OPCODE_FETCH, RAM_RD, RAM_WR, MEM_ACCESS, LVD_DET, POR_DET} <= 7'h00;
    endtask

    task results;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this bound only cuts a hang.
    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge CLK);
        RSTN <= 1;
        wait_run();
        rd(OFS_CAUSE, 32'h0);
        rd(OFS_CONTROL, 32'h2);
        rd(12'h020, 32'h0);
        `CHK(rerr, 1'b1)
        wr(OFS_CAUSE, 32'hFF);
        rd(OFS_CAUSE, 32'h0);
        wr(OFS_REGION_BASE, 32'h100);
        wr(OFS_REGION_LIMIT, 32'h1FF);
        wr(OFS_CONTROL, 32'h3);
        wr(OFS_IRQ_ENABLE, 32'h97);
        fire(6, 0);
        $display("test setup done");
        for (int i = 0; i < 5; i++) begin
            if (i >= 1 && i <= 3) begin
                fire(i, 1);
                @(negedge CLK);
                `CHK(CORE_RESET_N, 1'b1)
            end
            fire(i, 0);
            wait_run();
            rd(OFS_CAUSE, 32'(1) << bits[i]);
            `CHK(IRQ, 1'b1)
            rd(OFS_CAUSE, 32'h0);
            wr(OFS_IRQ_CLEAR, 32'hFF);
            rd(OFS_IRQ_STATUS, 32'h0);
            `CHK(IRQ, 1'b0)
            $display("test source %0d done", i);
        end
        wr(OFS_IRQ_ENABLE, 32'h0);
        fire(0, 0);
        wait_run();
        `CHK(IRQ, 1'b0)
        rd(OFS_IRQ_STATUS, 32'h10);
        @(posedge CLK);
        sup_go <= 1;
        @(posedge CLK);
        sup_go <= 0;
        wait_run();
        rd(OFS_CAUSE, 32'h0);
        // A new option-byte code must be taken at the next release.
        OPT_FREQ <= 3'h2;
        fire(0, 0);
        wait_run();
        // Power-on must wipe the watchdog flag left by the reset just before.
        fire(5, 0);
        wait_run();
        rd(OFS_CAUSE, 32'h0);
        $display("test pin and power-on done");
        results();
    end
endmodule
